/* File: hw/uic_pkg.sv */
// constants, register map and types of the universal input conditioning block
package uic_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FILTER_OFS = 8'h04;
  localparam logic [7:0] STRETCH_OFS = 8'h08;
  localparam logic [7:0] WINLEN_OFS = 8'h0C;
  localparam logic [7:0] RESET_AT_OFS = 8'h10;
  localparam logic [7:0] COUNT_OFS = 8'h14;
  localparam logic [7:0] RESULT_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] MASK_OFS = 8'h20;
  localparam logic [7:0] LEVEL_OFS = 8'h24;
  // control fields
  localparam int MODE_LSB = 0;
  localparam int INVERT_BIT = 2;
  localparam int STRETCH_LSB = 3;
  localparam int DECAY_LSB = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FILTER_RESET = 32'h0000_000A;
  localparam logic [31:0] STRETCH_RESET = 32'h0000_0001;
  localparam logic [31:0] WINLEN_RESET = 32'h0000_0001;
  // status bits
  localparam int ST_VALUE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_DAYCLR = 2;
  localparam int ST_BITS = 3;
  localparam int TOD_W = 17;
  typedef enum logic [1:0] {MODE_OFF, MODE_DIGITAL, MODE_CNT_DAY, MODE_CNT_INTRVL} mode_e;
  typedef enum logic [1:0] {STR_OFF, STR_UP, STR_DOWN, STR_BOTH} stretch_e;
  typedef enum logic [2:0] {DEC_OFF, DEC_MIN, DEC_MAX, DEC_AVG, DEC_MED, DEC_RMS} decay_e;
endpackage : uic_pkg

/* File: hw/universal_input_conditioning.sv */
// debounce, edge stretch, pulse counter and decay statistic for one universal input
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module universal_input_conditioning import uic_pkg::*; #(
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int DEPTH = 8,
  parameter int VW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // input signal and timebase
  input wire logic sig_in,
  input wire logic meas_tick,
  input wire logic [TOD_W-1:0] tod_sec,
  // measurement pipeline
  output logic level_out,
  output logic meas_valid,
  output logic [31:0] meas_value,
  output logic log_fault,
  output logic irq
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [31:0] ctrl, filter_ms, stretch_s, winlen, reset_at, count, result;
  logic [ST_BITS-1:0] status, mask;
  logic [31:0] ms_div, stable_ms, hold_ms;
  logic ms_tick, deb, deb_q;
  logic [TOD_W-1:0] tod_q;
  logic [VW-1:0] win [DEPTH];
  logic [CW-1:0] fill;

  // bus decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  wire mapped = paddr[1:0] == 2'b00 && paddr <= LEVEL_OFS;
  wire [1:0] mode = ctrl[MODE_LSB +: 2];
  wire [1:0] str = ctrl[STRETCH_LSB +: 2];
  wire [2:0] dsel = ctrl[DECAY_LSB +: 3];
  wire counter_mode = mode == MODE_CNT_DAY || mode == MODE_CNT_INTRVL;
  wire raw = (mode == MODE_DIGITAL && ctrl[INVERT_BIT]) ? !sig_in : sig_in;
  wire rise = deb && !deb_q;
  wire fall = !deb && deb_q;
  wire day_hit = mode == MODE_CNT_DAY && tod_sec != tod_q && tod_sec == reset_at[TOD_W-1:0];
  wire tick = meas_tick && mode != MODE_OFF;
  wire win_fault = winlen > DEPTH;
  wire [CW-1:0] xlen = win_fault ? CW'(DEPTH) : (winlen == 0 ? CW'(1) : CW'(winlen));
  wire [31:0] cnt_now = count + {31'd0, rise};

  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr)
      CTRL_OFS: rd_mux = ctrl;
      FILTER_OFS: rd_mux = filter_ms;
      STRETCH_OFS: rd_mux = stretch_s;
      WINLEN_OFS: rd_mux = winlen;
      RESET_AT_OFS: rd_mux = reset_at;
      COUNT_OFS: rd_mux = count;
      RESULT_OFS: rd_mux = result;
      STATUS_OFS: rd_mux = {{(32-ST_BITS){1'b0}}, status};
      MASK_OFS: rd_mux = {{(32-ST_BITS){1'b0}}, mask};
      LEVEL_OFS: rd_mux = {30'd0, level_out, deb};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // no wait state: answer prepared in setup, taken at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      filter_ms <= FILTER_RESET;
      stretch_s <= STRETCH_RESET;
      winlen <= WINLEN_RESET;
      reset_at <= 32'h0000_0000;
      mask <= '0;
    end else if (wr) begin
      if (paddr == CTRL_OFS) ctrl <= pwdata;
      if (paddr == FILTER_OFS) filter_ms <= pwdata;
      if (paddr == STRETCH_OFS) stretch_s <= pwdata;
      if (paddr == WINLEN_OFS) winlen <= pwdata;
      if (paddr == RESET_AT_OFS) reset_at <= pwdata;
      if (paddr == MASK_OFS) mask <= pwdata[ST_BITS-1:0];
    end
  end

  // sticky events; a set in the clearing cycle wins
  wire [ST_BITS-1:0] events = {day_hit, tick && win_fault, tick};
  wire [ST_BITS-1:0] w1c = (wr && paddr == STATUS_OFS) ? pwdata[ST_BITS-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~w1c) | events;
      irq <= |(((status & ~w1c) | events) & mask);
    end
  end

  // millisecond enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div <= 32'd0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_div == MS_DIV - 1;
      ms_div <= (ms_div == MS_DIV - 1) ? 32'd0 : ms_div + 32'd1;
    end
  end

  // debounce: one tick beyond filter_ms, so a change seen just before a tick cannot pass early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb <= 1'b0;
      deb_q <= 1'b0;
      stable_ms <= 32'd0;
    end else begin
      deb_q <= deb;
      if (raw == deb) begin
        stable_ms <= 32'd0;
      end else if (filter_ms == 32'd0 || stable_ms > filter_ms) begin
        deb <= raw;
        stable_ms <= 32'd0;
      end else if (ms_tick) begin
        stable_ms <= stable_ms + 32'd1;
      end
    end
  end

  // stretch: hold_ms is loaded one above the target so a partial first ms never shortens it
  wire up_q = str == STR_UP || str == STR_BOTH;
  wire dn_q = str == STR_DOWN || str == STR_BOTH;
  wire [31:0] hold_load = stretch_s * MS_PER_S + 32'd1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b0;
      hold_ms <= 32'd0;
    end else if (hold_ms != 0) begin
      if (ms_tick) hold_ms <= hold_ms - 32'd1;
    end else if (deb != level_out) begin
      level_out <= deb;
      if ((deb && up_q) || (!deb && dn_q)) hold_ms <= hold_load;
    end
  end

  // pulse accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'd0;
      tod_q <= '0;
    end else begin
      tod_q <= tod_sec;
      if (!counter_mode || day_hit) count <= 32'd0;
      else if (mode == MODE_CNT_INTRVL && tick) count <= 32'd0;
      else if (rise) count <= count + 32'd1;
    end
  end

  // newest sample and the window as it stands after this tick
  logic [31:0] sample;
  always_comb begin
    unique case (mode)
      MODE_DIGITAL: sample = {31'd0, level_out};
      MODE_CNT_INTRVL: sample = cnt_now;
      default: sample = count;
    endcase
  end
  wire [VW-1:0] samp_v = (|sample[31:VW]) ? {VW{1'b1}} : sample[VW-1:0];
  logic [VW-1:0] nwin [DEPTH];
  always_comb begin
    nwin[0] = samp_v;
    for (int i = 1; i < DEPTH; i++) nwin[i] = win[i-1];
  end
  wire [CW-1:0] n_eff = (fill + CW'(1) < xlen) ? fill + CW'(1) : xlen;

  function automatic logic [VW-1:0] isqrt(input logic [2*VW-1:0] v);
    logic [VW-1:0] r;
    r = '0;
    for (int b = VW - 1; b >= 0; b--) begin
      if ((2*VW)'(r | VW'(1 << b)) * (2*VW)'(r | VW'(1 << b)) <= v) r = r | VW'(1 << b);
    end
    return r;
  endfunction : isqrt

  // statistics over the first n_eff entries of the new window
  logic [VW-1:0] vmin, vmax, vmed;
  logic [VW+3:0] vsum;
  logic [2*VW+3:0] vsq;
  logic [CW-1:0] lt, eq;
  always_comb begin
    vmin = {VW{1'b1}};
    vmax = '0;
    vmed = '0;
    vsum = '0;
    vsq = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (CW'(i) < n_eff) begin
        if (nwin[i] < vmin) vmin = nwin[i];
        if (nwin[i] > vmax) vmax = nwin[i];
        vsum = vsum + (VW+4)'(nwin[i]);
        vsq = vsq + (2*VW+4)'(nwin[i] * nwin[i]);
      end
    end
    // median by rank: the entry whose rank span covers the lower middle index
    for (int i = 0; i < DEPTH; i++) begin
      lt = '0;
      eq = '0;
      for (int j = 0; j < DEPTH; j++) begin
        if (CW'(j) < n_eff && nwin[j] < nwin[i]) lt = lt + CW'(1);
        if (CW'(j) < n_eff && nwin[j] == nwin[i]) eq = eq + CW'(1);
      end
      if (CW'(i) < n_eff && lt <= (n_eff - CW'(1)) / 2 && (n_eff - CW'(1)) / 2 < lt + eq) vmed = nwin[i];
    end
  end
  wire [VW+3:0] vavg = vsum / (VW+4)'(n_eff);
  wire [2*VW+3:0] vmsq = vsq / (2*VW+4)'(n_eff);
  logic [31:0] dec_val;
  always_comb begin
    unique case (dsel)
      DEC_MIN: dec_val = {{(32-VW){1'b0}}, vmin};
      DEC_MAX: dec_val = {{(32-VW){1'b0}}, vmax};
      DEC_AVG: dec_val = {{(32-VW){1'b0}}, vavg[VW-1:0]};
      DEC_MED: dec_val = {{(32-VW){1'b0}}, vmed};
      DEC_RMS: dec_val = {{(32-VW){1'b0}}, isqrt(vmsq[2*VW-1:0])};
      default: dec_val = sample;
    endcase
  end
  wire [31:0] next_result = (mode == MODE_CNT_INTRVL) ? dec_val : sample;

  // one value per tick; window and result move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) win[i] <= '0;
      fill <= '0;
      result <= 32'h0000_0000;
      meas_value <= 32'h0000_0000;
      meas_valid <= 1'b0;
      log_fault <= 1'b0;
    end else begin
      meas_valid <= tick;
      log_fault <= tick && win_fault;
      if (tick) begin
        for (int i = 0; i < DEPTH; i++) win[i] <= nwin[i];
        if (fill < CW'(DEPTH)) fill <= fill + CW'(1);
        result <= next_result;
        meas_value <= next_result;
      end
      if (mode != MODE_CNT_INTRVL) fill <= '0;
    end
  end

  // checks
  debounce_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(deb) |-> $past(filter_ms) == 0 || $past(stable_ms) > $past(filter_ms))
    else $error("level accepted before filter time");
  digital_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_DIGITAL && ctrl[INVERT_BIT] |-> raw == !sig_in)
    else $error("invert not applied");
  up_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(level_out) && up_q && stretch_s != 0 |=> level_out [*8])
    else $error("stretched high level dropped early");
  down_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(level_out) && dn_q && stretch_s != 0 |=> !level_out [*8])
    else $error("stretched low level rose early");
  no_stretch_a: assert property (@(posedge pclk) disable iff (!presetn)
    str == STR_OFF && $stable(str) && hold_ms == 0 && deb != level_out |=> level_out == $past(deb))
    else $error("output not following input with stretch off");
  day_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    day_hit |=> count == 0)
    else $error("day counter not cleared");
  intrvl_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_CNT_INTRVL && tick && !day_hit |=> count == 0 && meas_value == $past(dec_val))
    else $error("interval counter not cleared on value");
  one_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    meas_valid |=> !meas_valid || $past(meas_tick, 1))
    else $error("value produced without tick");
  decay_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && dsel == DEC_OFF |=> meas_value == $past(sample))
    else $error("decay off changed value");
  min_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick |-> vmin <= vmax && vmed >= vmin && vmed <= vmax)
    else $error("min max median out of order");
  fault_log_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && win_fault |=> log_fault && status[ST_FAULT])
    else $error("window fault not raised");
endmodule : universal_input_conditioning
`default_nettype wire

/* File: test/pulse_source.sv */
// model of the external switch or pulse source on the raw input
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested level and driven input
  input wire logic want,
  output logic sig_in
);
  // a contact source always drives a level, so there is no released state to model
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_in <= 1'b0;
    end else begin
      sig_in <= want;
    end
  end
endmodule : pulse_source
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the universal input conditioning block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uic_pkg::*;
  // short ms divider keeps the one second stretch near 4k cycles
  localparam int unsigned MSD = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, want = 0, meas_tick = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [TOD_W-1:0] tod_sec = '0;
  logic [31:0] prdata, meas_value, q;
  logic pready, pslverr, level_out, meas_valid, log_fault, irq, sig_in, e, b;
  logic [32:0] expq[$];
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  logic [31:0] rs = 32'd56412;
  int dexp[6][3] = '{'{0, 0, 0}, '{1, 1, 1}, '{1, 7, 7}, '{1, 4, 4}, '{1, 1, 1}, '{1, 5, 5}};

  universal_input_conditioning #(.MS_DIV(MSD)) universal_input_conditioning_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sig_in(sig_in), .meas_tick(meas_tick), .tod_sec(tod_sec),
    .level_out(level_out), .meas_valid(meas_valid), .meas_value(meas_value), .log_fault(log_fault), .irq(irq));
  pulse_source pulse_source_i (.pclk(pclk), .presetn(presetn), .want(want), .sig_in(sig_in));

  always #12.5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc_n

  // one transfer; waits on pready rather than assuming the wait-state count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk({e, q}, exp);
  endtask : rd

  task automatic lvl(input logic [32:0] exp);
    chk({32'h0000_0000, level_out}, exp);
  endtask : lvl

  task automatic put(input logic v, input int n);
    @(posedge pclk);
    want <= v;
    cyc_n(n);
  endtask : put

  task automatic pulses(input int k);
    repeat (k) begin
      put(1'b1, 10 + int'(rnd() % 6));
      put(1'b0, 10 + int'(rnd() % 6));
    end
  endtask : pulses

  task automatic tick(input logic [32:0] exp);
    @(posedge pclk);
    meas_tick <= 1'b1;
    expq.push_back(exp);
    @(posedge pclk);
    meas_tick <= 1'b0;
    cyc_n(3);
  endtask : tick

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (meas_valid === 1'b1) begin
      chk({log_fault, meas_value}, expq.size() > 0 ? expq.pop_front() : 33'h1_FFFF_FFFF);
    end
    if (cyc == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS, {1'b0, CTRL_RESET});
    rd(FILTER_OFS, {1'b0, FILTER_RESET});
    rd(STRETCH_OFS, {1'b0, STRETCH_RESET});
    rd(WINLEN_OFS, {1'b0, WINLEN_RESET});
    rd(MASK_OFS, 33'h0);
    rd(8'h40, 33'h1_0000_0000);
    wr(FILTER_OFS, 32'h0000_0002);
    wr(CTRL_OFS, 32'h0000_0001);
    put(1'b1, 3);
    put(1'b0, 30);
    lvl(33'h0);
    put(1'b1, 30);
    lvl(33'h1);
    tick(33'h1);
    wr(CTRL_OFS, 32'h0000_0005);
    cyc_n(30);
    lvl(33'h0);
    put(1'b0, 30);
    lvl(33'h1);
    wr(FILTER_OFS, 32'h0000_0001);
    // up, down, both: start from the level whose edge the option stretches
    for (int k = 1; k < 4; k++) begin
      b = (k == 2);
      wr(CTRL_OFS, 32'h0000_0001);
      put(b, 30);
      wr(CTRL_OFS, 32'h0000_0001 | (k << STRETCH_LSB));
      put(!b, 12);
      put(b, 2000);
      lvl({32'h0000_0000, !b});
      cyc_n(3000);
      lvl({32'h0000_0000, b});
    end
    // the falling edge of the both-edges pass holds the output low for another stretch
    put(1'b1, 16);
    lvl(33'h0);
    wr(CTRL_OFS, 32'h0000_0001);
    cyc_n(4100);
    put(1'b1, 16);
    lvl(33'h1);
    put(1'b0, 16);
    lvl(33'h0);
    wr(WINLEN_OFS, 32'h0000_0002);
    wr(CTRL_OFS, 32'h0000_0003);
    pulses(3);
    tick(33'h3);
    put(1'b1, 2);
    put(1'b0, 12);
    tick(33'h0);
    @(posedge pclk);
    meas_tick <= 1'b1;
    expq.push_back(33'h0);
    expq.push_back(33'h0);
    cyc_n(2);
    meas_tick <= 1'b0;
    cyc_n(3);
    for (int d = 1; d < 6; d++) begin
      wr(CTRL_OFS, 32'h0000_0000);
      wr(CTRL_OFS, 32'h0000_0003 | (d << DECAY_LSB));
      pulses(1);
      tick(33'(dexp[d][0]));
      pulses(7);
      tick(33'(dexp[d][1]));
      pulses(1);
      tick(33'(dexp[d][2]));
    end
    wr(CTRL_OFS, 32'h0000_0043);
    wr(STATUS_OFS, 32'h0000_0007);
    wr(MASK_OFS, 32'h0000_0002);
    wr(WINLEN_OFS, 32'h0000_0009);
    tick(33'h1_0000_0007);
    rd(STATUS_OFS, 33'h3);
    chk({32'h0000_0000, irq}, 33'h1);
    // irq is registered, one cycle behind the mask that moves it and in step with status
    wr(MASK_OFS, 32'h0000_0000);
    cyc_n(2);
    chk({32'h0000_0000, irq}, 33'h0);
    wr(MASK_OFS, 32'h0000_0002);
    cyc_n(2);
    chk({32'h0000_0000, irq}, 33'h1);
    wr(STATUS_OFS, 32'h0000_0002);
    cyc_n(2);
    chk({32'h0000_0000, irq}, 33'h0);
    wr(WINLEN_OFS, 32'h0000_0001);
    wr(RESET_AT_OFS, 32'h0000_0005);
    tod_sec <= 17'h0_0004;
    wr(CTRL_OFS, 32'h0000_0002);
    pulses(2);
    tick(33'h2);
    @(posedge pclk);
    tod_sec <= 17'h0_0005;
    cyc_n(3);
    tick(33'h0);
    cyc_n(5);
    chk(33'(expq.size()), 33'h0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
